// ---- pkg/btb_cfg.svh ----
// Constants for the branch target buffer lookup block.
// Assumes a 32-bit fetch address whose bit 0 is the least significant bit.
// Summary of operation
// - Lookup miss predicts no taken branch
// - Allocate only branches resolved taken
// - Not-taken hit still redirects to sequential address
// - Set index from big-endian address bits 21-27
// - Tag from big-endian bits 0-20 and 28-29
// - Lowest two address bits ignored entirely
// - Hit when any of four ways matches
// - Keyed by fetch-group start address only
// - Missed taken branch writes entry for group unless all four ways are locked
// - Other group address never matches entry
// - Entry holds valid, lock, tag, target, offset, counter
// - New entry counter starts strongly taken
// - Locked entries are never evicted
// - Updates from branch unit take lookup slot
`ifndef BTB_CFG_SVH
`define BTB_CFG_SVH

// ==========================================================
// Geometry
`define BTB_SETS 128
`define BTB_WAYS 4
`define BTB_SET_W 7
`define BTB_WAY_W 2
`define BTB_TAG_W 23
`define BTB_TGT_W 30
`define BTB_SLOT_W 3
`define BTB_CNT_W 2

// ==========================================================
// Address fields, little-endian positions
`define BTB_IDX_MSB 10
`define BTB_IDX_LSB 4
`define BTB_TAG_HI_MSB 31
`define BTB_TAG_HI_LSB 11
`define BTB_TAG_LO_MSB 3
`define BTB_TAG_LO_LSB 2
`define BTB_LINE_MSB 31
`define BTB_LINE_LSB 5
`define BTB_LINE_W 27

// ==========================================================
// Counter states
`define BTB_CNT_STRONG_TAKEN 2'h3
`define BTB_CNT_STRONG_NOT 2'h0

// ==========================================================
// Register map and bus answers
`define BTB_ADDR_W 8
`define BTB_REG_CTRL 8'h00
`define BTB_REG_HITS 8'h04
`define BTB_REG_MISSES 8'h08
`define BTB_REG_ALLOCS 8'h0c
`define BTB_CTRL_EN_BIT 0
`define BTB_CTRL_FLUSH_BIT 1
`define BTB_CTRL_RESET 1'b1
`define BTB_RESP_OKAY 2'h0
`define BTB_RESP_SLVERR 2'h2

`endif

// ---- pkg/btb_pkg.sv ----
// Types shared by the branch target buffer lookup block.
// Assumes btb_cfg.svh on the include path.
`include "btb_cfg.svh"
package btb_pkg;

	// ==========================================================
	// Stored entry; valid and lock live in separate resettable arrays
	typedef struct packed {
		logic [`BTB_TAG_W-1:0]  tag;
		logic [`BTB_TGT_W-1:0]  target;
		logic [`BTB_SLOT_W-1:0] slot;
		logic [`BTB_CNT_W-1:0]  cnt;
	} btb_entry_t;

	// ==========================================================
	// Request from the branch execution unit
	typedef struct packed {
		logic                   valid;
		logic [31:0]            fetch_addr;
		logic                   taken;
		logic [`BTB_TGT_W-1:0]  target;
		logic [`BTB_SLOT_W-1:0] slot;
		logic                   lock;
	} btb_upd_t;

	// ==========================================================
	// Prediction to the fetch unit
	typedef struct packed {
		logic                   valid;
		logic                   hit;
		logic [`BTB_WAY_W-1:0]  way;
		logic                   taken;
		logic                   redirect;
		logic [`BTB_TGT_W-1:0]  addr;
		logic [`BTB_SLOT_W-1:0] slot;
	} btb_pred_t;

endpackage

// ---- hdl/btb_way_pick.sv ----
// Victim way choice for one set of the branch target buffer.
// Assumes valid and lock bits of the set are read on the same clock.
`timescale 1ns/1ns
`include "btb_cfg.svh"
module btb_way_pick (
	// Set state
	input  wire logic [`BTB_WAYS-1:0]  vld_i,
	input  wire logic [`BTB_WAYS-1:0]  lck_i,
	input  wire logic [`BTB_WAY_W-1:0] ptr_i,
	// Choice
	output logic      [`BTB_WAY_W-1:0] way_o,
	output logic                       ok_o,
	output logic                       rr_o
);

	// ==========================================================
	// Free ways seen from the round-robin pointer
	logic [`BTB_WAYS-1:0]  free_rot;
	logic [`BTB_WAY_W-1:0] inv_way;
	logic [`BTB_WAY_W-1:0] rot_k;
	logic                  has_inv;

	for (genvar k = 0; k < `BTB_WAYS; k++) begin : g_rot
		assign free_rot[k] = !lck_i[2'(ptr_i + 2'(k))];
	end

	assign has_inv = |(~vld_i);
	assign inv_way = !vld_i[0] ? 2'h0 : !vld_i[1] ? 2'h1 : !vld_i[2] ? 2'h2 : 2'h3;
	assign rot_k   = free_rot[0] ? 2'h0 : free_rot[1] ? 2'h1 : free_rot[2] ? 2'h2 : 2'h3;

	// Invalid ways first, locked ways never
	assign way_o = has_inv ? inv_way : 2'(ptr_i + rot_k);
	assign ok_o  = has_inv || (|free_rot);
	assign rr_o  = !has_inv;

endmodule // btb_way_pick

// ---- hdl/btb_lookup.sv ----
// Fetch-address indexed branch target buffer, 128 sets of 4 ways.
// Assumes fetch unit and branch unit share core_clk_i; AXI4-Lite on the same clock.
`timescale 1ns/1ns
`include "btb_cfg.svh"
module btb_lookup (
	// Clock and reset
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_n_i,
	// Fetch unit
	input  wire logic                   fetch_valid_i,
	input  wire logic [31:0]            fetch_addr_i,
	output btb_pkg::btb_pred_t          pred_o,
	output logic                        fetch_bubble_o,
	// Branch execution unit
	input  wire btb_pkg::btb_upd_t      upd_i,
	// AXI4-Lite write
	input  wire logic                   s_axi_awvalid_i,
	input  wire logic [`BTB_ADDR_W-1:0] s_axi_awaddr_i,
	output logic                        s_axi_awready_o,
	input  wire logic                   s_axi_wvalid_i,
	input  wire logic [31:0]            s_axi_wdata_i,
	input  wire logic [3:0]             s_axi_wstrb_i,
	output logic                        s_axi_wready_o,
	output logic                        s_axi_bvalid_o,
	output logic [1:0]                  s_axi_bresp_o,
	input  wire logic                   s_axi_bready_i,
	// AXI4-Lite read
	input  wire logic                   s_axi_arvalid_i,
	input  wire logic [`BTB_ADDR_W-1:0] s_axi_araddr_i,
	output logic                        s_axi_arready_o,
	output logic                        s_axi_rvalid_o,
	output logic [31:0]                 s_axi_rdata_o,
	output logic [1:0]                  s_axi_rresp_o,
	input  wire logic                   s_axi_rready_i
);

	// ==========================================================
	// Storage
	btb_pkg::btb_entry_t         ent [`BTB_SETS][`BTB_WAYS];
	logic [`BTB_WAYS-1:0]        vld [`BTB_SETS];
	logic [`BTB_WAYS-1:0]        lck [`BTB_SETS];
	logic [`BTB_WAY_W-1:0]       rr  [`BTB_SETS];

	// ==========================================================
	// Stage one: an update steals the slot from a fetch lookup
	logic                        s1_lk;
	logic                        s1_up;
	logic [31:0]                 s1_addr;
	btb_pkg::btb_upd_t           s1_upd;
	logic                        ctrl_en;
	logic                        flush;

	wire                         lk_go = fetch_valid_i && !upd_i.valid;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s1_lk   <= 1'b0;
			s1_up   <= 1'b0;
			s1_addr <= 32'h0;
			s1_upd  <= '0;
		end else begin
			s1_lk   <= lk_go;
			s1_up   <= upd_i.valid;
			s1_addr <= upd_i.valid ? upd_i.fetch_addr : fetch_addr_i;
			s1_upd  <= upd_i;
		end
	end

	// ==========================================================
	// Index and tag; the two lowest address bits take no part
	wire [`BTB_SET_W-1:0] s1_set = s1_addr[`BTB_IDX_MSB:`BTB_IDX_LSB];
	wire [`BTB_TAG_W-1:0] s1_tag = {s1_addr[`BTB_TAG_HI_MSB:`BTB_TAG_HI_LSB],
		s1_addr[`BTB_TAG_LO_MSB:`BTB_TAG_LO_LSB]};

	logic [`BTB_WAYS-1:0] hit_vec;
	for (genvar w = 0; w < `BTB_WAYS; w++) begin : g_way
		assign hit_vec[w] = vld[s1_set][w] && (ent[s1_set][w].tag == s1_tag);
	end

	// Updates refresh a matching entry, so at most one way matches
	wire                  hit_any = |hit_vec;
	wire [`BTB_WAY_W-1:0] hit_way = hit_vec[3] ? 2'h3 : hit_vec[2] ? 2'h2 :
		hit_vec[1] ? 2'h1 : 2'h0;
	btb_pkg::btb_entry_t  hit_ent;
	assign hit_ent = ent[s1_set][hit_way];

	// ==========================================================
	// Prediction
	wire                  lk_hit  = s1_lk && hit_any && ctrl_en;
	wire [`BTB_LINE_W-1:0] s1_line = s1_addr[`BTB_LINE_MSB:`BTB_LINE_LSB];
	wire [`BTB_TGT_W-1:0] seq_word = (hit_ent.slot == 3'h0) ?
		{27'(s1_line + 27'h1), 3'h0} : {s1_line, hit_ent.slot};
	wire                  pr_taken = lk_hit && hit_ent.cnt[1];
	btb_pkg::btb_pred_t   next_pred;

	assign next_pred.valid    = s1_lk;
	assign next_pred.hit      = lk_hit;
	assign next_pred.way      = lk_hit ? hit_way : 2'h0;
	assign next_pred.taken    = pr_taken;
	assign next_pred.redirect = lk_hit;
	assign next_pred.addr     = !lk_hit ? 30'h0 : pr_taken ? hit_ent.target : seq_word;
	assign next_pred.slot     = lk_hit ? hit_ent.slot : 3'h0;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pred_o         <= '0;
			fetch_bubble_o <= 1'b0;
		end else begin
			pred_o         <= next_pred;
			fetch_bubble_o <= upd_i.valid;
		end
	end

	// ==========================================================
	// Update and allocation
	logic [`BTB_WAY_W-1:0] pick_way;
	logic                  pick_ok;
	logic                  pick_rr;

	btb_way_pick u_pick (
		.vld_i (vld[s1_set]),
		.lck_i (lck[s1_set]),
		.ptr_i (rr[s1_set]),
		.way_o (pick_way),
		.ok_o  (pick_ok),
		.rr_o  (pick_rr)
	);

	// Not-taken results only train an existing entry, never evict it
	wire upd_hit  = s1_up && hit_any;
	wire alloc_we = s1_up && !hit_any && s1_upd.taken && pick_ok;

	wire [1:0] cnt_inc = (hit_ent.cnt == `BTB_CNT_STRONG_TAKEN) ? hit_ent.cnt :
		2'(hit_ent.cnt + 2'h1);
	wire [1:0] cnt_dec = (hit_ent.cnt == `BTB_CNT_STRONG_NOT) ? hit_ent.cnt :
		2'(hit_ent.cnt - 2'h1);

	btb_pkg::btb_entry_t upd_ent;
	btb_pkg::btb_entry_t new_ent;
	assign upd_ent.tag    = hit_ent.tag;
	assign upd_ent.target = s1_upd.taken ? s1_upd.target : hit_ent.target;
	assign upd_ent.slot   = s1_upd.taken ? s1_upd.slot : hit_ent.slot;
	assign upd_ent.cnt    = s1_upd.taken ? cnt_inc : cnt_dec;
	assign new_ent.tag    = s1_tag;
	assign new_ent.target = s1_upd.target;
	assign new_ent.slot   = s1_upd.slot;
	assign new_ent.cnt    = `BTB_CNT_STRONG_TAKEN;

	// Entry payload carries no reset; valid bits guard it
	always_ff @(posedge core_clk_i) begin
		if (alloc_we)
			ent[s1_set][pick_way] <= new_ent;
		else if (upd_hit)
			ent[s1_set][hit_way] <= upd_ent;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			for (int s = 0; s < `BTB_SETS; s++) begin
				vld[s] <= '0;
				lck[s] <= '0;
				rr[s]  <= '0;
			end
		end else begin
			if (flush)
				for (int s = 0; s < `BTB_SETS; s++)
					vld[s] <= vld[s] & lck[s];
			if (alloc_we) begin
				vld[s1_set][pick_way] <= 1'b1;
				lck[s1_set][pick_way] <= s1_upd.lock;
				if (pick_rr)
					rr[s1_set] <= 2'(pick_way + 2'h1);
			end else if (upd_hit) begin
				lck[s1_set][hit_way] <= s1_upd.lock;
			end
		end
	end

	// ==========================================================
	// Statistics; an event in the clearing cycle still counts
	logic [31:0] hit_cnt;
	logic [31:0] miss_cnt;
	logic [31:0] alloc_cnt;
	logic        wr_go;
	logic [`BTB_ADDR_W-1:0] aw_addr;

	wire clr_hit   = wr_go && (aw_addr == `BTB_REG_HITS);
	wire clr_miss  = wr_go && (aw_addr == `BTB_REG_MISSES);
	wire clr_alloc = wr_go && (aw_addr == `BTB_REG_ALLOCS);
	wire ev_miss   = s1_lk && !lk_hit;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			hit_cnt   <= 32'h0;
			miss_cnt  <= 32'h0;
			alloc_cnt <= 32'h0;
		end else begin
			hit_cnt   <= (clr_hit ? 32'h0 : hit_cnt) + {31'h0, lk_hit};
			miss_cnt  <= (clr_miss ? 32'h0 : miss_cnt) + {31'h0, ev_miss};
			alloc_cnt <= (clr_alloc ? 32'h0 : alloc_cnt) + {31'h0, alloc_we};
		end
	end

	// ==========================================================
	// AXI4-Lite write channel; address and data taken in either order
	logic        aw_full;
	logic        w_full;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	wire aw_fire = s_axi_awvalid_i && s_axi_awready_o;
	wire w_fire  = s_axi_wvalid_i && s_axi_wready_o;
	wire wr_ctrl = aw_addr == `BTB_REG_CTRL;
	wire wr_map  = wr_ctrl || clr_hit || clr_miss || clr_alloc || (aw_addr == `BTB_REG_HITS);
	assign wr_go = aw_full && w_full && !s_axi_bvalid_o;
	wire wr_mapd = (aw_addr == `BTB_REG_CTRL) || (aw_addr == `BTB_REG_HITS) ||
		(aw_addr == `BTB_REG_MISSES) || (aw_addr == `BTB_REG_ALLOCS);
	wire ctrl_we = wr_go && wr_ctrl && w_strb[0];

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `BTB_RESP_OKAY;
			aw_full         <= 1'b0;
			w_full          <= 1'b0;
			aw_addr         <= '0;
			w_data          <= 32'h0;
			w_strb          <= 4'h0;
			ctrl_en         <= `BTB_CTRL_RESET;
			flush           <= 1'b0;
		end else begin
			flush <= ctrl_we && w_data[`BTB_CTRL_FLUSH_BIT];
			if (aw_fire) begin
				aw_full         <= 1'b1;
				aw_addr         <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (w_fire) begin
				w_full         <= 1'b1;
				w_data         <= s_axi_wdata_i;
				w_strb         <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (wr_go) begin
				aw_full        <= 1'b0;
				w_full         <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= (wr_mapd && wr_map) ? `BTB_RESP_OKAY : `BTB_RESP_SLVERR;
				if (ctrl_we)
					ctrl_en <= w_data[`BTB_CTRL_EN_BIT];
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel; answer one cycle after the address
	wire [`BTB_ADDR_W-1:0] ra = s_axi_araddr_i;
	wire rd_map = (ra == `BTB_REG_CTRL) || (ra == `BTB_REG_HITS) ||
		(ra == `BTB_REG_MISSES) || (ra == `BTB_REG_ALLOCS);
	wire [31:0] rd_val = (ra == `BTB_REG_CTRL) ? {31'h0, ctrl_en} :
		(ra == `BTB_REG_HITS) ? hit_cnt :
		(ra == `BTB_REG_MISSES) ? miss_cnt :
		(ra == `BTB_REG_ALLOCS) ? alloc_cnt : 32'h0;
	wire ar_fire = s_axi_arvalid_i && s_axi_arready_o;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0;
			s_axi_rresp_o   <= `BTB_RESP_OKAY;
		end else if (ar_fire) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= rd_val;
			s_axi_rresp_o   <= rd_map ? `BTB_RESP_OKAY : `BTB_RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	a_miss_not_taken: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		pred_o.valid && !pred_o.hit |-> !pred_o.taken && !pred_o.redirect)
		else $error("miss predicted a taken branch");

	a_alloc_only_taken: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s1_up && !s1_upd.taken && !hit_any && !flush
		|=> vld[$past(s1_set)] == $past(vld[s1_set]))
		else $error("not-taken branch changed the valid bits");

	a_hit_redirects: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s1_lk && lk_hit && !hit_ent.cnt[1] |=> pred_o.redirect && !pred_o.taken)
		else $error("not-taken hit did not redirect");

	a_index_from_addr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		lk_go |=> s1_set == $past(fetch_addr_i[`BTB_IDX_MSB:`BTB_IDX_LSB]))
		else $error("set index taken from wrong bits");

	a_alloc_tag_kept: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		alloc_we |=> ent[$past(s1_set)][$past(pick_way)].tag == $past(s1_tag)
			&& vld[$past(s1_set)][$past(pick_way)])
		else $error("allocated tag not stored");

	a_hit_reported: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s1_lk && hit_any && ctrl_en |=> pred_o.hit && pred_o.way == $past(hit_way))
		else $error("matching way not reported");

	a_alloc_strong: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		alloc_we |=> ent[$past(s1_set)][$past(pick_way)].cnt == `BTB_CNT_STRONG_TAKEN)
		else $error("new entry counter not strongly taken");

	a_update_bubble: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		upd_i.valid |=> fetch_bubble_o && !s1_lk ##1 !pred_o.valid)
		else $error("update did not take the lookup slot");

	a_lock_spared: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		alloc_we && vld[s1_set][pick_way] |-> !lck[s1_set][pick_way])
		else $error("locked way replaced");

	a_result_latency: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		lk_go |-> ##2 pred_o.valid)
		else $error("lookup result not two cycles later");

endmodule // btb_lookup

// ---- tb/btb_front_model.sv ----
// Fetch unit and branch execution unit model facing the branch target buffer.
// Assumes the bench calls one task at a time and waits for it to return.
`timescale 1ns/1ns
`include "btb_cfg.svh"
module btb_front_model (
	// Clock
	input  wire logic               core_clk_i,
	// Toward the block
	output logic                    fetch_valid_o,
	output logic [31:0]             fetch_addr_o,
	output btb_pkg::btb_upd_t       upd_o,
	// From the block
	input  wire btb_pkg::btb_pred_t pred_i,
	input  wire logic               fetch_bubble_i
);
	initial begin
		fetch_valid_o = 1'b0;
		fetch_addr_o  = 32'h0000_0000;
		upd_o         = '0;
	end

	// ==========================================================
	// Released payload turns to junk so a stale value never helps
	task automatic idle();
		fetch_valid_o <= 1'b0;
		fetch_addr_o  <= ~fetch_addr_o;
		upd_o         <= {1'b0, ~upd_o[66:0]};
	endtask

	// ==========================================================
	// Lookup keyed by the group start; low two bits kept clear
	task automatic look(input logic [31:0] a, output btb_pkg::btb_pred_t p);
		@(posedge core_clk_i);
		fetch_valid_o <= 1'b1;
		fetch_addr_o  <= {a[31:2], 2'h0};
		@(posedge core_clk_i);
		idle();
		@(posedge core_clk_i);
		#1 p = pred_i;
	endtask

	task automatic look_pair(input logic [31:0] a, input logic [31:0] b,
			output btb_pkg::btb_pred_t p1, output btb_pkg::btb_pred_t p2);
		@(posedge core_clk_i);
		fetch_valid_o <= 1'b1;
		fetch_addr_o  <= {a[31:2], 2'h0};
		@(posedge core_clk_i);
		fetch_addr_o  <= {b[31:2], 2'h0};
		@(posedge core_clk_i);
		idle();
		#1 p1 = pred_i;
		@(posedge core_clk_i);
		#1 p2 = pred_i;
	endtask

	// ==========================================================
	// Only this unit writes entries, with the group address as key
	task automatic upd(input logic [31:0] a, input logic tk, input logic [29:0] tg,
			input logic [2:0] sl, input logic lk, output logic bub);
		@(posedge core_clk_i);
		upd_o <= {1'b1, a[31:2], 2'h0, tk, tg, sl, lk};
		@(posedge core_clk_i);
		idle();
		#1 bub = fetch_bubble_i;
	endtask

	// Lookup and update in one cycle; the lookup loses its slot
	task automatic clash(input logic [31:0] a, output logic bub, output logic pv);
		@(posedge core_clk_i);
		fetch_valid_o <= 1'b1;
		fetch_addr_o  <= {a[31:2], 2'h0};
		upd_o         <= {1'b1, a[31:2], 2'h0, 1'b0, 30'h0, 3'h0, 1'b0};
		@(posedge core_clk_i);
		idle();
		#1 bub = fetch_bubble_i;
		@(posedge core_clk_i);
		#1 pv = pred_i.valid;
	endtask
endmodule // btb_front_model

// ---- tb/branch_target_buffer_lookup_tb.sv ----
// Self-checking bench for the branch target buffer lookup block.
// Assumes btb_front_model as the fetch side and an AXI4-Lite master here.
`timescale 1ns/1ns
`include "btb_cfg.svh"
module branch_target_buffer_lookup_tb;
	logic               core_clk = 1'b0;
	logic               rst_n = 1'b0;
	logic               fv;
	logic [31:0]        fa;
	btb_pkg::btb_upd_t  up;
	btb_pkg::btb_pred_t pr;
	logic               bub;
	logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic               arvalid = 1'b0, rready = 1'b0;
	logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]        wdata = 32'h0, rdata;
	logic               awready, wready, bvalid, arready, rvalid;
	logic [1:0]         bresp, rresp;
	int                 fails = 0, tests_run = 0, cyc = 0;
	localparam logic [31:0] GA = 32'h0000_1000;
	localparam logic [29:0] TG = 30'h0000_0403;

	always #25 core_clk = ~core_clk;

	btb_front_model FM (.core_clk_i(core_clk), .fetch_valid_o(fv), .fetch_addr_o(fa),
		.upd_o(up), .pred_i(pr), .fetch_bubble_i(bub));

	btb_lookup DUT (.core_clk_i(core_clk), .rst_n_i(rst_n), .fetch_valid_i(fv),
		.fetch_addr_i(fa), .pred_o(pr), .fetch_bubble_o(bub), .upd_i(up),
		.s_axi_awvalid_i(awvalid), .s_axi_awaddr_i(awaddr), .s_axi_awready_o(awready),
		.s_axi_wvalid_i(wvalid), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
		.s_axi_wready_o(wready), .s_axi_bvalid_o(bvalid), .s_axi_bresp_o(bresp),
		.s_axi_bready_i(bready), .s_axi_arvalid_i(arvalid), .s_axi_araddr_i(araddr),
		.s_axi_arready_o(arready), .s_axi_rvalid_o(rvalid), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rready_i(rready));

	// ==========================================================
	// Verdict and watchdog
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Whole run needs a few hundred cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails = fails + 1;
			summarize();
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic pexp(input btb_pkg::btb_pred_t p, input logic h, input logic [1:0] w,
			input logic t, input logic [29:0] ad, input logic [2:0] sl, input string what);
		btb_pkg::btb_pred_t e;
		e = {1'b1, h, w, t, h, ad, sl};
		chk(64'(p), 64'(e), what);
	endtask

	// ==========================================================
	// AXI4-Lite master, one transfer at a time
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge core_clk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		bready  <= 1'b1;
		while (!done) begin
			@(posedge core_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				bready <= 1'b0;
				r = bresp;
				done = 1'b1;
			end
		end
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge core_clk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		while (!done) begin
			@(posedge core_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				rready <= 1'b0;
				d = rdata;
				r = rresp;
				done = 1'b1;
			end
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_alloc();
		btb_pkg::btb_pred_t p;
		logic b;
		FM.look(GA, p);
		pexp(p, 1'b0, 2'h0, 1'b0, 30'h0, 3'h0, "cold miss");
		FM.upd(GA, 1'b0, TG, 3'h2, 1'b0, b);
		chk(64'(b), 64'h1, "update bubble");
		FM.look(GA, p);
		pexp(p, 1'b0, 2'h0, 1'b0, 30'h0, 3'h0, "not taken kept out");
		FM.upd(GA, 1'b1, TG, 3'h2, 1'b0, b);
		FM.look(GA, p);
		pexp(p, 1'b1, 2'h0, 1'b1, TG, 3'h2, "taken allocated");
		FM.look(GA + 32'h10, p);
		pexp(p, 1'b0, 2'h0, 1'b0, 30'h0, 3'h0, "next group set");
		FM.look(GA ^ 32'h800, p);
		pexp(p, 1'b0, 2'h0, 1'b0, 30'h0, 3'h0, "upper tag bit");
		FM.look(GA | 32'h4, p);
		pexp(p, 1'b0, 2'h0, 1'b0, 30'h0, 3'h0, "same branch other group");
		$display("test alloc done");
	endtask

	task automatic t_counter();
		btb_pkg::btb_pred_t p;
		logic b;
		FM.upd(GA, 1'b0, TG, 3'h2, 1'b0, b);
		FM.look(GA, p);
		pexp(p, 1'b1, 2'h0, 1'b1, TG, 3'h2, "one not taken still taken");
		FM.upd(GA, 1'b0, TG, 3'h2, 1'b0, b);
		FM.look(GA, p);
		pexp(p, 1'b1, 2'h0, 1'b0, {GA[31:5], 3'h2}, 3'h2, "sequential redirect");
		$display("test counter done");
	endtask

	task automatic t_pipe();
		btb_pkg::btb_pred_t p1, p2;
		logic b, pv;
		FM.look_pair(GA, GA + 32'h10, p1, p2);
		chk(64'({p1.valid, p1.hit, p2.valid, p2.hit}), 64'he, "back to back");
		FM.clash(GA + 32'h20, b, pv);
		chk(64'({b, pv}), 64'h2, "update takes lookup slot");
		$display("test pipe done");
	endtask

	// Fill one set, then try to allocate a fifth tag into it
	task automatic t_ways(input logic [31:0] base, input logic lk);
		btb_pkg::btb_pred_t p;
		logic b;
		int n;
		n = 0;
		for (int k = 0; k < 4; k++) begin
			FM.upd(base | (k << 11), 1'b1, 30'h100 + 30'(k), 3'h1, lk, b);
			FM.look(base | (k << 11), p);
			pexp(p, 1'b1, 2'(k), 1'b1, 30'h100 + 30'(k), 3'h1, "invalid way first");
		end
		FM.upd(base | (4 << 11), 1'b1, 30'h104, 3'h1, 1'b0, b);
		FM.look(base | (4 << 11), p);
		chk(64'(p.hit), 64'(!lk), "fifth tag");
		for (int k = 0; k < 4; k++) begin
			FM.look(base | (k << 11), p);
			if (p.hit === 1'b1) n++;
		end
		chk(64'(n), lk ? 64'h4 : 64'h3, "survivors");
		$display("test ways done");
	endtask

	task automatic t_regs();
		btb_pkg::btb_pred_t p;
		logic [31:0] d;
		logic [1:0]  r;
		logic        b;
		axi_rd(`BTB_REG_CTRL, d, r);
		chk(64'({r, d}), 64'h1, "ctrl reset");
		axi_wr(`BTB_REG_CTRL, 32'h0, r);
		FM.look(GA, p);
		pexp(p, 1'b0, 2'h0, 1'b0, 30'h0, 3'h0, "disabled miss");
		axi_wr(`BTB_REG_CTRL, 32'h1, r);
		axi_wr(`BTB_REG_HITS, 32'h0, r);
		FM.look(GA, p);
		axi_rd(`BTB_REG_HITS, d, r);
		chk(64'({r, d}), 64'h1, "hit count");
		axi_rd(8'h10, d, r);
		chk(64'({r, d}), 64'({`BTB_RESP_SLVERR, 32'h0}), "unmapped read");
		axi_wr(8'h14, 32'h5, r);
		chk(64'(r), 64'(`BTB_RESP_SLVERR), "unmapped write");
		// Flush drops unlocked entries only
		axi_wr(`BTB_REG_MISSES, 32'h0, r);
		chk(64'(r), 64'(`BTB_RESP_OKAY), "mapped write");
		axi_wr(`BTB_REG_CTRL, 32'h3, r);
		FM.look(GA, p);
		pexp(p, 1'b0, 2'h0, 1'b0, 30'h0, 3'h0, "flushed entry");
		FM.look(32'h0000_0060, p);
		chk(64'(p.hit), 64'h1, "locked entry kept");
		axi_rd(`BTB_REG_MISSES, d, r);
		chk(64'({r, d}), 64'h1, "miss count");
		axi_wr(`BTB_REG_ALLOCS, 32'h0, r);
		FM.upd(GA, 1'b1, TG, 3'h2, 1'b0, b);
		axi_rd(`BTB_REG_ALLOCS, d, r);
		chk(64'({r, d}), 64'h1, "alloc count");
		$display("test regs done");
	endtask

	// Mid-run reset restores the control word and drops locked entries too
	task automatic t_reset();
		btb_pkg::btb_pred_t p;
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(`BTB_REG_CTRL, 32'h0, r);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		axi_rd(`BTB_REG_CTRL, d, r);
		chk(64'({r, d}), 64'h1, "ctrl after reset");
		FM.look(32'h0000_0060, p);
		pexp(p, 1'b0, 2'h0, 1'b0, 30'h0, 3'h0, "reset clears entries");
		$display("test reset done");
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		t_alloc();
		t_counter();
		t_pipe();
		t_ways(32'h0000_0050, 1'b0);
		t_ways(32'h0000_0060, 1'b1);
		t_regs();
		t_reset();
		summarize();
	end
endmodule // branch_target_buffer_lookup_tb
